// *** pio_pkg.sv ***
// package of register map, field positions and mode codes for the parallel port block
package pio_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NPORT  = 7;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_A_DATA   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_A_DIR    = 8'h01;
   localparam logic [ADDR_W-1:0] OFS_F_DATA   = 8'h02;
   localparam logic [ADDR_W-1:0] OFS_F_DIR    = 8'h03;
   localparam logic [ADDR_W-1:0] OFS_B_DATA   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_B_DIR    = 8'h05;
   localparam logic [ADDR_W-1:0] OFS_C_DATA   = 8'h06;
   localparam logic [ADDR_W-1:0] OFS_C_DIR    = 8'h07;
   localparam logic [ADDR_W-1:0] OFS_D_DATA   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_D_DIR    = 8'h09;
   localparam logic [ADDR_W-1:0] OFS_E_DATA   = 8'h0A;
   localparam logic [ADDR_W-1:0] OFS_PULLUP   = 8'h2C;
   localparam logic [ADDR_W-1:0] OFS_OPTIONS2 = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_SYSCFG   = 8'h3F;
   localparam logic [ADDR_W-1:0] OFS_G_DATA   = 8'h7E;
   localparam logic [ADDR_W-1:0] OFS_G_DIR    = 8'h7F;

   // field positions
   localparam int OPTIONS_TWO_PORT_C_OPEN_DRAIN_BIT = 5;
   localparam int OPTIONS_TWO_IRV_BIT  = 4;
   localparam int OPTIONS_TWO_DWOM_BIT = 3;
   localparam int SYSCFG_PULLUP_REG_ENABLE  = 2;
   localparam int PU_B_BIT      = 0;
   localparam int PU_F_BIT      = 1;
   localparam int PU_G_BIT      = 2;
   localparam int PU_H_BIT      = 3;
   localparam int PU_W          = 4;
   localparam int G_RW_BIT      = 7;
   localparam int XA_W          = 6;
   localparam int D_W           = 6;

   // port indices into the synchroniser array
   localparam int P_A = 0;
   localparam int P_B = 1;
   localparam int P_C = 2;
   localparam int P_D = 3;
   localparam int P_E = 4;
   localparam int P_F = 5;
   localparam int P_G = 6;

   // reset values and fixed patterns
   localparam logic [DATA_W-1:0] RST_BYTE    = 8'h00;
   localparam logic [DATA_W-1:0] ALL_ONES    = 8'hFF;
   localparam logic [DATA_W-1:0] G_REDUCED_M = 8'h80;
   localparam logic [1:0]        D_PAD       = 2'h0;

   // operating mode straps
   typedef enum logic [1:0] {
      PIO_MODE_BOOT   = 2'b00,
      PIO_MODE_TEST   = 2'b01,
      PIO_MODE_SINGLE = 2'b10,
      PIO_MODE_EXP    = 2'b11
   } pio_mode_t;

endpackage

// *** pio_ports.sv ***
// seven parallel ports, six with direction control, bus takeover, open drain and pullups
//
// Design decision made here: the strobed register port.
module pio_ports
   import pio_pkg::*;
#(
   parameter logic REDUCED = 1'b0
) (
   input  wire logic              CLK,
   input  wire logic              RST,
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [DATA_W-1:0] WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic      [DATA_W-1:0] RDATA,
   input  wire logic [1:0]        MODE,
   input  wire logic [7:0]        PA_IN,
   output logic      [7:0]        PA_OUT,
   output logic      [7:0]        PA_OE_N,
   input  wire logic [7:0]        PB_IN,
   output logic      [7:0]        PB_OUT,
   output logic      [7:0]        PB_OE_N,
   input  wire logic [7:0]        PC_IN,
   output logic      [7:0]        PC_OUT,
   output logic      [7:0]        PC_OE_N,
   input  wire logic [D_W-1:0]    PD_IN,
   output logic      [D_W-1:0]    PD_OUT,
   output logic      [D_W-1:0]    PD_OE_N,
   input  wire logic [7:0]        PE_IN,
   input  wire logic [7:0]        PF_IN,
   output logic      [7:0]        PF_OUT,
   output logic      [7:0]        PF_OE_N,
   input  wire logic [7:0]        PG_IN,
   output logic      [7:0]        PG_OUT,
   output logic      [7:0]        PG_OE_N,
   input  wire logic [7:0]        TMR_EN,
   input  wire logic [7:0]        TMR_OE,
   input  wire logic [7:0]        TMR_OUT,
   input  wire logic [D_W-1:0]    SER_EN,
   input  wire logic [D_W-1:0]    SER_OE,
   input  wire logic [D_W-1:0]    SER_OUT,
   input  wire logic [15:0]       BUS_ADDR,
   input  wire logic [XA_W-1:0]   BUS_XADDR,
   input  wire logic [XA_W-1:0]   XA_EN,
   input  wire logic              BUS_RW,
   input  wire logic [7:0]        BUS_WR_DATA,
   input  wire logic              IRV_VALID,
   input  wire logic [7:0]        IRV_DATA,
   input  wire logic              BUS_CLK_E,
   output logic                   E_PIN,
   output logic      [7:0]        EXT_DATA_IN,
   output logic                   PU_B,
   output logic                   PU_F,
   output logic                   PU_G,
   output logic                   PU_H
);

   typedef struct packed {
      logic [7:0]                    dat_a;
      logic [7:0]                    dir_a;
      logic [7:0]                    dat_b;
      logic [7:0]                    dir_b;
      logic [7:0]                    dat_c;
      logic [7:0]                    dir_c;
      logic [D_W-1:0]                dat_d;
      logic [D_W-1:0]                dir_d;
      logic [7:0]                    dat_f;
      logic [7:0]                    dir_f;
      logic [7:0]                    dat_g;
      logic [7:0]                    dir_g;
      logic                          port_c_open_drain;
      logic                          dwom;
      logic                          irv;
      logic                          irv_locked;
      logic                          pullup_reg_enable;
      logic [PU_W-1:0]               pullup_assign_reg;
      logic [NPORT-1:0][DATA_W-1:0]  sync1;
      logic [NPORT-1:0][DATA_W-1:0]  sync2;
      logic [DATA_W-1:0]             rdata;
      logic [7:0]                    a_out;
      logic [7:0]                    a_oen;
      logic [7:0]                    b_out;
      logic [7:0]                    b_oen;
      logic [7:0]                    c_out;
      logic [7:0]                    c_oen;
      logic [D_W-1:0]                d_out;
      logic [D_W-1:0]                d_oen;
      logic [7:0]                    f_out;
      logic [7:0]                    f_oen;
      logic [7:0]                    g_out;
      logic [7:0]                    g_oen;
      logic                          e_pin;
      logic [7:0]                    ext_din;
      logic [PU_W-1:0]               pu;
   } pio_state_t;

   localparam pio_state_t RST_STATE = '{
      dat_a: RST_BYTE, dir_a: RST_BYTE, dat_b: RST_BYTE, dir_b: RST_BYTE,
      dat_c: RST_BYTE, dir_c: RST_BYTE,
      dat_d: RST_BYTE[D_W-1:0], dir_d: RST_BYTE[D_W-1:0],
      dat_f: RST_BYTE, dir_f: RST_BYTE, dat_g: RST_BYTE, dir_g: RST_BYTE,
      port_c_open_drain: 1'b0, dwom: 1'b0, irv: 1'b0, irv_locked: 1'b0, pullup_reg_enable: 1'b0,
      pullup_assign_reg: '0, sync1: '0, sync2: '0, rdata: RST_BYTE,
      a_out: RST_BYTE, a_oen: ALL_ONES, b_out: RST_BYTE, b_oen: ALL_ONES,
      c_out: RST_BYTE, c_oen: ALL_ONES,
      d_out: RST_BYTE[D_W-1:0], d_oen: ALL_ONES[D_W-1:0],
      f_out: RST_BYTE, f_oen: ALL_ONES, g_out: RST_BYTE, g_oen: ALL_ONES,
      e_pin: 1'b0, ext_din: RST_BYTE, pu: '0
   };

   // pins absent on the reduced variant never drive and read as zero
   localparam logic [7:0] G_PRESENT = REDUCED ? G_REDUCED_M : ALL_ONES;

   // external address halves: high byte to port B, low byte to port F
   localparam int ADR_LO_LSB = 0;
   localparam int ADR_LO_MSB = DATA_W - 1;
   localparam int ADR_HI_LSB = DATA_W;
   localparam int ADR_HI_MSB = 2 * DATA_W - 1;

   pio_state_t                   state_reg;
   pio_state_t                   state_next;
   logic [NPORT-1:0][DATA_W-1:0] pins_in;
   logic                         expanded;
   logic [7:0]                   c_od_mask;
   logic [D_W-1:0]               d_od_mask;
   logic [7:0]                   a_rd;
   logic [7:0]                   c_rd;
   logic [7:0]                   d_rd;

   // gather all pin levels for the synchroniser
   // pads move at any time; only sync2 may be read, sync1 can be metastable
   assign pins_in[P_A] = PA_IN;
   assign pins_in[P_B] = PB_IN;
   assign pins_in[P_C] = PC_IN;
   assign pins_in[P_D] = {D_PAD, PD_IN};
   assign pins_in[P_E] = PE_IN;
   assign pins_in[P_F] = PF_IN;
   assign pins_in[P_G] = PG_IN & G_PRESENT;

   // test and expanded modes hand the bus pins to the memory interface
   assign expanded = (pio_mode_t'(MODE) == PIO_MODE_EXP) ||
                     (pio_mode_t'(MODE) == PIO_MODE_TEST);

   // output bits of an open-drain port read back the driver, not the pin
   // driver level readback
   assign c_od_mask = (state_reg.port_c_open_drain && !expanded) ? state_reg.dir_c : RST_BYTE;
   assign d_od_mask = state_reg.dwom ? (state_reg.dir_d & ~SER_EN) : RST_BYTE[D_W-1:0];

   assign a_rd = state_reg.sync2[P_A];
   assign c_rd = (state_reg.sync2[P_C] & ~c_od_mask) | (state_reg.dat_c & c_od_mask);
   assign d_rd = {D_PAD, (state_reg.sync2[P_D][D_W-1:0] & ~d_od_mask) |
                         (state_reg.dat_d & d_od_mask)};

   // next-state logic for registers, read path and pin drivers
   always_comb begin
      state_next = state_reg;

      state_next.sync1 = pins_in;
      state_next.sync2 = state_reg.sync1;

      // register writes; port E has nothing to write
      // data and direction registers
      if (WR) begin
         unique case (ADDR)
            OFS_A_DATA: state_next.dat_a = WDATA;
            OFS_A_DIR:  state_next.dir_a = WDATA;
            OFS_B_DATA: state_next.dat_b = WDATA;
            OFS_B_DIR:  state_next.dir_b = WDATA;
            OFS_C_DATA: state_next.dat_c = WDATA;
            OFS_C_DIR:  state_next.dir_c = WDATA;
            OFS_D_DATA: state_next.dat_d = WDATA[D_W-1:0];
            OFS_D_DIR:  state_next.dir_d = WDATA[D_W-1:0];
            OFS_F_DATA: state_next.dat_f = WDATA;
            OFS_F_DIR:  state_next.dir_f = WDATA;
            OFS_G_DATA: state_next.dat_g = WDATA;
            OFS_G_DIR:  state_next.dir_g = WDATA;
            OFS_PULLUP: state_next.pullup_assign_reg  = WDATA[PU_W-1:0];
            OFS_SYSCFG: state_next.pullup_reg_enable = WDATA[SYSCFG_PULLUP_REG_ENABLE];
            OFS_OPTIONS2: begin
               state_next.port_c_open_drain = WDATA[OPTIONS_TWO_PORT_C_OPEN_DRAIN_BIT];
               state_next.dwom = WDATA[OPTIONS_TWO_DWOM_BIT];
               // a first write of zero also locks: software gets one try
               // write-once visibility bit
               if (!state_reg.irv_locked) begin
                  state_next.irv        = WDATA[OPTIONS_TWO_IRV_BIT];
                  state_next.irv_locked = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // read data stands for the one cycle after the strobe, zero otherwise
      // zero between reads keeps stale pin data off the shared read bus
      state_next.rdata = RST_BYTE;
      if (RD) begin
         unique case (ADDR)
            OFS_A_DATA: state_next.rdata = a_rd;
            OFS_A_DIR:  state_next.rdata = state_reg.dir_a;
            OFS_B_DATA: state_next.rdata = state_reg.sync2[P_B];
            OFS_B_DIR:  state_next.rdata = state_reg.dir_b;
            OFS_C_DATA: state_next.rdata = c_rd;
            OFS_C_DIR:  state_next.rdata = state_reg.dir_c;
            OFS_D_DATA: state_next.rdata = d_rd;
            OFS_D_DIR:  state_next.rdata = {D_PAD, state_reg.dir_d};
            OFS_E_DATA: state_next.rdata = state_reg.sync2[P_E];
            OFS_F_DATA: state_next.rdata = state_reg.sync2[P_F];
            OFS_F_DIR:  state_next.rdata = state_reg.dir_f;
            OFS_G_DATA: state_next.rdata = state_reg.sync2[P_G];
            OFS_G_DIR:  state_next.rdata = state_reg.dir_g & G_PRESENT;
            OFS_PULLUP: state_next.rdata = {{(DATA_W-PU_W){1'b0}}, state_reg.pullup_assign_reg};
            OFS_SYSCFG: begin
               state_next.rdata[SYSCFG_PULLUP_REG_ENABLE] = state_reg.pullup_reg_enable;
            end
            OFS_OPTIONS2: begin
               state_next.rdata[OPTIONS_TWO_PORT_C_OPEN_DRAIN_BIT] = state_reg.port_c_open_drain;
               state_next.rdata[OPTIONS_TWO_IRV_BIT]  = state_reg.irv;
               state_next.rdata[OPTIONS_TWO_DWOM_BIT] = state_reg.dwom;
            end
            default: state_next.rdata = RST_BYTE;
         endcase
      end

      // port A: latch drives output bits, timer owns the bits it enables
      // latch drives outputs only
      state_next.a_out = (TMR_EN & TMR_OUT) | (~TMR_EN & state_reg.dat_a);
      state_next.a_oen = ~((TMR_EN & TMR_OE) | (~TMR_EN & state_reg.dir_a));

      // port B: high address byte in expanded modes
      // high address takeover
      if (expanded) begin
         state_next.b_out = BUS_ADDR[ADR_HI_MSB:ADR_HI_LSB];
         state_next.b_oen = RST_BYTE;
      end else begin
         state_next.b_out = state_reg.dat_b;
         state_next.b_oen = ~state_reg.dir_b;
      end

      // port C: data bus, visibility data, open drain or plain outputs
      // data bus takeover
      if (expanded) begin
         state_next.c_out = BUS_WR_DATA;
         state_next.c_oen = ALL_ONES;
         // an external write owns the data bus, so it beats visibility data
         if (!BUS_RW) begin
            state_next.c_oen = RST_BYTE;
         end else if (state_reg.irv && IRV_VALID) begin
            state_next.c_out = IRV_DATA;
            state_next.c_oen = RST_BYTE;
         end
      end else if (state_reg.port_c_open_drain) begin
         // pull down for 0, float for 1
         state_next.c_out = RST_BYTE;
         state_next.c_oen = ~(state_reg.dir_c & ~state_reg.dat_c);
      end else begin
         state_next.c_out = state_reg.dat_c;
         state_next.c_oen = ~state_reg.dir_c;
      end

      // port D: serial peripherals own enabled bits, gpio may be open drain
      // open drain only touches bits the serial blocks leave to gpio
      // serial takeover of port D
      if (state_reg.dwom) begin
         state_next.d_out = SER_EN & SER_OUT;
         state_next.d_oen = ~((SER_EN & SER_OE) |
                              (~SER_EN & state_reg.dir_d & ~state_reg.dat_d));
      end else begin
         state_next.d_out = (SER_EN & SER_OUT) | (~SER_EN & state_reg.dat_d);
         state_next.d_oen = ~((SER_EN & SER_OE) | (~SER_EN & state_reg.dir_d));
      end

      // port F: low address byte in expanded modes
      // low address takeover
      if (expanded) begin
         state_next.f_out = BUS_ADDR[ADR_LO_MSB:ADR_LO_LSB];
         state_next.f_oen = RST_BYTE;
      end else begin
         state_next.f_out = state_reg.dat_f;
         state_next.f_oen = ~state_reg.dir_f;
      end

      // port G: read/write strobe and extended address in expanded modes
      state_next.g_out = state_reg.dat_g;
      state_next.g_oen = ~state_reg.dir_g;
      if (expanded) begin
         state_next.g_out[G_RW_BIT] = BUS_RW;
         state_next.g_oen[G_RW_BIT] = 1'b0;
         state_next.g_out[XA_W-1:0] = (XA_EN & BUS_XADDR) |
                                      (~XA_EN & state_reg.dat_g[XA_W-1:0]);
         state_next.g_oen[XA_W-1:0] = ~(XA_EN | state_reg.dir_g[XA_W-1:0]);
      end
      // masked last so that no branch above can enable a missing pad
      // absent pins stay undriven
      state_next.g_out = state_next.g_out & G_PRESENT;
      state_next.g_oen = state_next.g_oen | ~G_PRESENT;

      // bus clock pin, held low by the visibility bit in single-chip modes
      // registered like every pad, so the pin trails the bus clock a cycle
      // clock pin inhibit
      state_next.e_pin = (!expanded && state_reg.irv) ? 1'b0 : BUS_CLK_E;

      // data bus levels for the memory interface
      // one flop past the synchroniser: pin data reaches the bus three edges late
      state_next.ext_din = state_reg.sync2[P_C];

      // pullups gated by the enable bit; B and F are address outputs when expanded
      // per-port pullup enables
      state_next.pu[PU_B_BIT] = state_reg.pullup_reg_enable && state_reg.pullup_assign_reg[PU_B_BIT] && !expanded;
      state_next.pu[PU_F_BIT] = state_reg.pullup_reg_enable && state_reg.pullup_assign_reg[PU_F_BIT] && !expanded;
      state_next.pu[PU_G_BIT] = state_reg.pullup_reg_enable && state_reg.pullup_assign_reg[PU_G_BIT];
      state_next.pu[PU_H_BIT] = state_reg.pullup_reg_enable && state_reg.pullup_assign_reg[PU_H_BIT];
   end

   // state register; reset releases every pin, bus pins too, which follow the mode from the first edge after
   // registered pads cost a cycle of latency but never glitch on decode
   // reset to inputs
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg <= RST_STATE;
      end else begin
         state_reg <= state_next;
      end
   end

   // every output straight from the state register
   assign RDATA       = state_reg.rdata;
   assign PA_OUT      = state_reg.a_out;
   assign PA_OE_N     = state_reg.a_oen;
   assign PB_OUT      = state_reg.b_out;
   assign PB_OE_N     = state_reg.b_oen;
   assign PC_OUT      = state_reg.c_out;
   assign PC_OE_N     = state_reg.c_oen;
   assign PD_OUT      = state_reg.d_out;
   assign PD_OE_N     = state_reg.d_oen;
   assign PF_OUT      = state_reg.f_out;
   assign PF_OE_N     = state_reg.f_oen;
   assign PG_OUT      = state_reg.g_out;
   assign PG_OE_N     = state_reg.g_oen;
   assign E_PIN       = state_reg.e_pin;
   assign EXT_DATA_IN = state_reg.ext_din;
   assign PU_B        = state_reg.pu[PU_B_BIT];
   assign PU_F        = state_reg.pu[PU_F_BIT];
   assign PU_G        = state_reg.pu[PU_G_BIT];
   assign PU_H        = state_reg.pu[PU_H_BIT];

endmodule

// *** pio_pin_model.sv ***
// far-side pad model: resolves one port's pads from device and outside drivers
module pio_pin_model #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] oe_n,
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] ext,
   output logic      [W-1:0] pin
);
   timeunit 1ns;
   timeprecision 100ps;
   // driven pads win
   // a released pad follows the outside device, so open drain ones read outside level
   assign pin = (out & ~oe_n) | (ext & oe_n);
endmodule

// *** pio_properties.sv ***
// concurrent checks on pin takeover, read data, pullups and e pin of the port block
module pio_properties
   import pio_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        RD,
   input wire logic [7:0]  RDATA,
   input wire logic [1:0]  MODE,
   input wire logic [7:0]  PA_OUT,
   input wire logic [7:0]  PA_OE_N,
   input wire logic [7:0]  TMR_EN,
   input wire logic [7:0]  TMR_OE,
   input wire logic [7:0]  TMR_OUT,
   input wire logic [7:0]  PB_OUT,
   input wire logic [7:0]  PB_OE_N,
   input wire logic [7:0]  PC_OUT,
   input wire logic [7:0]  PC_OE_N,
   input wire logic [7:0]  PG_OUT,
   input wire logic [7:0]  PG_OE_N,
   input wire logic [15:0] BUS_ADDR,
   input wire logic        BUS_RW,
   input wire logic [7:0]  BUS_WR_DATA,
   input wire logic        IRV_VALID,
   input wire logic        BUS_CLK_E,
   input wire logic        E_PIN,
   input wire logic        PU_B,
   input wire logic        PU_F
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // outputs lag their cause by one edge, so checks start one edge after reset
   sequence s_live;
      !$past(RST);
   endsequence
   sequence s_exp;
      !$past(RST) && $past(MODE[0]);
   endsequence

   property p_b_addr;
      s_exp |-> PB_OE_N == 8'h00 && PB_OUT == $past(BUS_ADDR[15:8]);
   endproperty
   a_b_addr: assert property (p_b_addr) else $error("port b off address");
   property p_g_rw;
      s_exp |-> !PG_OE_N[7] && PG_OUT[7] == $past(BUS_RW);
   endproperty
   a_g_rw: assert property (p_g_rw) else $error("g7 not strobe");
   property p_c_wr;
      s_exp ##0 !$past(BUS_RW) |-> PC_OE_N == 8'h00 && PC_OUT == $past(BUS_WR_DATA);
   endproperty
   a_c_wr: assert property (p_c_wr) else $error("port c not write data");
   property p_c_quiet;
      s_exp ##0 $past(BUS_RW && !IRV_VALID) |-> PC_OE_N == 8'hFF;
   endproperty
   a_c_quiet: assert property (p_c_quiet) else $error("port c driven idle");
   property p_e_low;
      E_PIN |-> $past(BUS_CLK_E);
   endproperty
   a_e_low: assert property (p_e_low) else $error("e pin high alone");
   property p_e_exp;
      s_exp |-> E_PIN == $past(BUS_CLK_E);
   endproperty
   a_e_exp: assert property (p_e_exp) else $error("e pin off clock");
   property p_tmr;
      s_live ##0 $past(TMR_EN) == 8'hFF |-> PA_OE_N == ~$past(TMR_OE)
         && ((PA_OUT ^ $past(TMR_OUT)) & $past(TMR_OE)) == 8'h00;
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer lost port a");
   property p_pu;
      PU_B || PU_F |-> !$past(MODE[0]);
   endproperty
   a_pu: assert property (p_pu) else $error("address pullup on");
   property p_rd;
      !$past(RD) |-> RDATA == 8'h00;
   endproperty
   a_rd: assert property (p_rd) else $error("read data unasked");
endmodule

bind pio_ports pio_properties u_props (.*);

// *** tb_top.sv ***
// self-checking bench for the parallel port block, random and corner stimulus
module tb_top
   import pio_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        CLK, RST, WR, RD, BUS_RW, IRV_VALID, BUS_CLK_E, E_PIN;
   logic        PU_B, PU_F, PU_G, PU_H;
   logic [1:0]  MODE;
   logic [7:0]  ADDR, WDATA, RDATA, PE_IN, IRV_DATA, BUS_WR_DATA, EXT_DATA_IN;
   logic [7:0]  PA_IN, PA_OUT, PA_OE_N, PB_IN, PB_OUT, PB_OE_N, PC_IN, PC_OUT, PC_OE_N;
   logic [7:0]  PF_IN, PF_OUT, PF_OE_N, PG_IN, PG_OUT, PG_OE_N, TMR_EN, TMR_OE, TMR_OUT;
   logic [5:0]  PD_IN, PD_OUT, PD_OE_N, SER_EN, SER_OE, SER_OUT, BUS_XADDR, XA_EN;
   logic [15:0] BUS_ADDR;
   logic [7:0]  ext [7];   // levels outside devices put on released pads
   logic [7:0]  dv [7];
   logic [7:0]  dd [7];
   logic [7:0]  d;
   int          error_cnt = 0;
   int          tests_run = 0;
   localparam logic [7:0] OFS_DAT [7] = '{OFS_A_DATA, OFS_B_DATA, OFS_C_DATA, OFS_D_DATA,
      OFS_E_DATA, OFS_F_DATA, OFS_G_DATA};
   localparam logic [7:0] OFS_DIR [7] = '{OFS_A_DIR, OFS_B_DIR, OFS_C_DIR, OFS_D_DIR,
      OFS_OPTIONS2, OFS_F_DIR, OFS_G_DIR};
   localparam int PL [6] = '{P_A, P_B, P_C, P_D, P_F, P_G};

   pio_ports #(.REDUCED(1'b0)) dut (.*);
   // pads of every two-way port resolved by the far-side model
   pio_pin_model #(8) u_pa (.oe_n(PA_OE_N), .out(PA_OUT), .ext(ext[P_A]), .pin(PA_IN));
   pio_pin_model #(8) u_pb (.oe_n(PB_OE_N), .out(PB_OUT), .ext(ext[P_B]), .pin(PB_IN));
   pio_pin_model #(8) u_pc (.oe_n(PC_OE_N), .out(PC_OUT), .ext(ext[P_C]), .pin(PC_IN));
   pio_pin_model #(6) u_pd (.oe_n(PD_OE_N), .out(PD_OUT), .ext(ext[P_D][5:0]), .pin(PD_IN));
   pio_pin_model #(8) u_pf (.oe_n(PF_OE_N), .out(PF_OUT), .ext(ext[P_F]), .pin(PF_IN));
   pio_pin_model #(8) u_pg (.oe_n(PG_OE_N), .out(PG_OUT), .ext(ext[P_G]), .pin(PG_IN));
   assign PE_IN = ext[P_E];

   // free-running bus clock
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   // one-cycle strobes, changed right after a rising edge
   task automatic wr(logic [7:0] a, logic [7:0] v);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 chk(nm, e, RDATA);
   endtask

   task automatic do_reset(logic [1:0] m);
      @(posedge CLK);
      RST <= 1'b1;
      MODE <= m;
      repeat (4) @(posedge CLK);
      RST <= 1'b0;
      tick(1);
   endtask

   // expected {oe_n, out} from direction, latch and peripheral takeover
   function automatic logic [15:0] exp_drv(logic [7:0] dir, dat, en, poe, pout);
      return {(~dir & ~en) | (~poe & en), (dat & ~en) | (pout & en)};
   endfunction

   function automatic logic [15:0] drv(int p);
      case (p)
         P_A: return {PA_OE_N, PA_OUT};
         P_B: return {PB_OE_N, PB_OUT};
         P_C: return {PC_OE_N, PC_OUT};
         P_D: return {2'b11, PD_OE_N, 2'b00, PD_OUT};
         P_F: return {PF_OE_N, PF_OUT};
         default: return {PG_OE_N, PG_OUT};
      endcase
   endfunction

   task automatic chk_port(int p);
      logic [7:0]  m, en, poe, pout;
      logic [15:0] e, g;
      m = (p == P_D) ? 8'h3F : 8'hFF;
      en = (p == P_A) ? TMR_EN : (p == P_D) ? {2'b00, SER_EN} : 8'h00;
      poe = (p == P_A) ? TMR_OE : {2'b00, SER_OE};
      pout = (p == P_A) ? TMR_OUT : {2'b00, SER_OUT};
      e = exp_drv(dv[p], dd[p], en, poe, pout);
      g = drv(p);
      chk("oe_n", e[15:8] | ~m, g[15:8] | ~m);
      chk("out", e[7:0] & ~e[15:8] & m, g[7:0] & ~e[15:8] & m);
      rd(OFS_DAT[p], ((e[7:0] & ~e[15:8]) | (ext[p] & e[15:8])) & m, "pin");
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // a hang is cut short well beyond the expected run length
   initial begin
      #100000;
      error_cnt++;
      conclude();
   end

   initial begin
      {RST, WR, RD, BUS_RW, IRV_VALID, BUS_CLK_E, MODE} = 8'h92;
      {ADDR, WDATA, TMR_EN, TMR_OE, TMR_OUT, BUS_WR_DATA, IRV_DATA} = '0;
      {SER_EN, SER_OE, SER_OUT, BUS_XADDR, XA_EN, BUS_ADDR} = '0;
      foreach (ext[i]) ext[i] = 8'h00;
      void'($urandom(32'hDF9D));
      do_reset(PIO_MODE_SINGLE);
      chk("oe_rst", 8'hFF, PA_OE_N & PB_OE_N & PC_OE_N & PF_OE_N & PG_OE_N);
      foreach (PL[j]) rd(OFS_DIR[PL[j]], 8'h00, "dir_rst");
      wr(8'h55, 8'hA5);
      rd(8'h55, 8'h00, "unmapped");
      $display("test reset done");
      // random gpio in both single-chip modes, first iteration of each pass with full takeover
      for (int k = 0; k < 2; k++) begin
         do_reset(k[0] ? PIO_MODE_BOOT : PIO_MODE_SINGLE);
         for (int i = 0; i < 8; i++) begin
            @(posedge CLK);
            TMR_EN <= (i == 0) ? 8'hFF : 8'($urandom);
            {TMR_OE, TMR_OUT} <= 16'($urandom);
            SER_EN <= (i == 0) ? 6'h3F : 6'($urandom);
            {SER_OE, SER_OUT} <= 12'($urandom);
            ext[P_E] <= 8'($urandom);
            foreach (PL[j]) begin
               dv[PL[j]] = 8'($urandom);
               dd[PL[j]] = 8'($urandom);
               ext[PL[j]] <= 8'($urandom);
               wr(OFS_DIR[PL[j]], dv[PL[j]]);
               wr(OFS_DAT[PL[j]], dd[PL[j]]);
            end
            wr(OFS_E_DATA, ~ext[P_E]);
            tick(6);
            foreach (PL[j]) chk_port(PL[j]);
            rd(OFS_E_DATA, ext[P_E], "port_e");
         end
      end
      $display("test gpio done");
      // open drain ports and the write-once visibility bit
      @(posedge CLK);
      SER_EN <= 6'h00;
      BUS_CLK_E <= 1'b1;
      do_reset(PIO_MODE_SINGLE);
      d = 8'($urandom);
      wr(OFS_OPTIONS2, 8'h38);
      wr(OFS_C_DIR, 8'hFF);
      wr(OFS_C_DATA, d);
      wr(OFS_D_DIR, 8'h3F);
      wr(OFS_D_DATA, d);
      tick(4);
      chk("c_od_oe", d, PC_OE_N);
      chk("c_od_out", 8'h00, PC_OUT & ~PC_OE_N);
      rd(OFS_C_DATA, d, "c_od_rd");
      rd(OFS_D_DATA, d & 8'h3F, "d_od_rd");
      chk("e_held", 8'h00, {7'h00, E_PIN});
      wr(OFS_OPTIONS2, 8'h00);
      rd(OFS_OPTIONS2, 8'h10, "vis_once");
      do_reset(PIO_MODE_SINGLE);
      rd(OFS_OPTIONS2, 8'h00, "vis_rst");
      chk("e_clk", 8'h01, {7'h00, E_PIN});
      $display("test open drain done");
      // expanded-type modes: bus takeover, visibility and pullups
      for (int k = 0; k < 2; k++) begin
         do_reset(k[0] ? PIO_MODE_EXP : PIO_MODE_TEST);
         @(posedge CLK);
         {BUS_ADDR, BUS_XADDR, IRV_DATA, BUS_WR_DATA} <= 38'({$urandom, $urandom});
         XA_EN <= 6'h3F;
         IRV_VALID <= 1'b1;
         wr(OFS_OPTIONS2, 8'h10);
         wr(OFS_PULLUP, 8'h0F);
         tick(3);
         chk("b_addr", BUS_ADDR[15:8], PB_OUT);
         chk("f_addr", BUS_ADDR[7:0], PF_OUT);
         chk("g_xa", {2'b00, BUS_XADDR}, {2'b00, PG_OUT[5:0]});
         chk("c_vis", IRV_DATA, PC_OUT & ~PC_OE_N);
         chk("ext_din", IRV_DATA, EXT_DATA_IN);
         chk("pu_off", 8'h00, {4'h0, PU_B, PU_F, PU_G, PU_H});
         wr(OFS_SYSCFG, 8'h04);
         @(posedge CLK);
         BUS_RW <= 1'b0;
         IRV_VALID <= 1'b0;
         tick(3);
         chk("pu_on", 8'h03, {4'h0, PU_B, PU_F, PU_G, PU_H});
         chk("c_wr", BUS_WR_DATA, PC_OUT);
         @(posedge CLK);
         BUS_RW <= 1'b1;
         tick(3);
         chk("c_idle", 8'hFF, PC_OE_N);
      end
      $display("test expanded done");
      conclude();
   end
endmodule
